// *** rtl/capture_compare_pwm_unit_regs.svh ***
// Register offsets, field positions, reset values and timing constants in ns
`ifndef CAPTURE_COMPARE_PWM_UNIT_REGS_SVH
`define CAPTURE_COMPARE_PWM_UNIT_REGS_SVH

// Per-channel banks: the channel index 0..6 is added to the base
`define CH_CTRL_BASE 8'h00
`define CH_DATA_LO_BASE 8'h08
`define CH_DATA_HI_BASE 8'h10
`define CH_STEER_BASE 8'h18
`define TSEL_ONE_ADDR 8'h20
`define TSEL_TWO_ADDR 8'h21
`define IRQ_FLAG_ADDR 8'h22
`define PIN_STATE_ADDR 8'h23

// Fields of channel_control
`define CTRL_MODE_LSB 0
`define CTRL_DUTY_LSB 4
`define CTRL_OCFG_LSB 6

// Reset values
`define CTRL_RESET 8'h00
`define TSEL_RESET 8'h00
`define STEER_RESET 4'h0

// Implemented bits of the timer-select registers
`define TSEL_ONE_MASK 8'hD7
`define TSEL_TWO_MASK 8'h17
`define TSEL_TWO_SMALL_MASK 8'h03

// Timing
`define CLK_PERIOD_NS 5
`define DEAD_BAND_NS 50

`endif

// *** rtl/ccpu_pkg.sv ***
// Types shared by the capture/compare/PWM unit
package ccpu_pkg;

   typedef enum logic [3:0] {
      MODE_OFF = 4'h0,
      MODE_RSVD_1 = 4'h1,
      MODE_CMP_TOGGLE = 4'h2,
      MODE_RSVD_3 = 4'h3,
      MODE_CAP_FALL = 4'h4,
      MODE_CAP_RISE = 4'h5,
      MODE_CAP_RISE4 = 4'h6,
      MODE_CAP_RISE16 = 4'h7,
      MODE_CMP_SET = 4'h8,
      MODE_CMP_CLEAR = 4'h9,
      MODE_CMP_SOFT = 4'hA,
      MODE_CMP_TRIG = 4'hB,
      MODE_PWM_0 = 4'hC,
      MODE_PWM_1 = 4'hD,
      MODE_PWM_2 = 4'hE,
      MODE_PWM_3 = 4'hF
   } channel_mode_t;

   typedef enum logic [1:0] {
      OCFG_SINGLE = 2'b00,
      OCFG_FWD = 2'b01,
      OCFG_HALF = 2'b10,
      OCFG_REV = 2'b11
   } output_config_t;

   typedef logic [2:0] timer_idx_t;

endpackage

// *** rtl/capture_if.sv ***
// Capture pin and mode from a channel to its edge detector
`timescale 1ns/1ps
interface capture_if;
   import ccpu_pkg::*;
   logic pin;
   channel_mode_t mode;
   logic capture;

   modport host (output pin, output mode, input capture);
   modport edge_side (input pin, input mode, output capture);
endinterface

// *** rtl/capture_edge_unit.sv ***
// Capture pin synchroniser, edge detector and capture prescaler
`timescale 1ns/1ps
module capture_edge_unit
   import ccpu_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   capture_if.edge_side cap
);

   logic sync1_reg;
   logic sync2_reg;
   logic last_reg;
   logic [3:0] pre_reg;
   logic sync1_next;
   logic sync2_next;
   logic last_next;
   logic [3:0] pre_next;
   logic rise;
   logic fall;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      sync1_next = cap.pin;
      sync2_next = sync1_reg;
      last_next = sync2_reg;
      rise = sync2_reg & ~last_reg;
      fall = ~sync2_reg & last_reg;
      pre_next = pre_reg;
      cap.capture = 1'b0;
      case (cap.mode)
         MODE_CAP_FALL: begin
            cap.capture = fall;
            pre_next = 4'h0;
         end
         MODE_CAP_RISE: begin
            cap.capture = rise;
            pre_next = 4'h0;
         end
         MODE_CAP_RISE4: begin
            if (rise) begin
               cap.capture = (pre_reg[1:0] == 2'b11);
               pre_next = {2'b00, pre_reg[1:0] + 2'b01};
            end
         end
         MODE_CAP_RISE16: begin
            if (rise) begin
               cap.capture = (pre_reg == 4'hF);
               pre_next = pre_reg + 4'h1;
            end
         end
         default: begin
            // Leaving capture clears the prescaler
            pre_next = 4'h0;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg <= 1'b0;
         pre_reg <= 4'h0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         last_reg <= last_next;
         pre_reg <= pre_next;
      end
   end

endmodule

// *** rtl/capture_compare_pwm_unit.sv ***
// Seven-channel capture/compare/PWM unit with its register file
`timescale 1ns/1ps
`include "capture_compare_pwm_unit_regs.svh"
module capture_compare_pwm_unit
   import ccpu_pkg::*;
#(
   parameter int NUM_CH = 7,
   parameter bit SMALL_MEMORY = 1'b0,
   parameter int DEAD_CYCLES =
      (`DEAD_BAND_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic [7:0][15:0] i_timer_count,
   output logic [7:0] o_timer_reset,
   input wire logic [6:0] i_cap_pin,
   output logic [6:0] o_channel_irq_flag,
   output logic [6:0] o_out_a,
   output logic [6:0] o_out_a_en,
   output logic [6:0] o_out_b,
   output logic [6:0] o_out_b_en,
   output logic [6:0] o_out_c,
   output logic [6:0] o_out_c_en,
   output logic [6:0] o_out_d,
   output logic [6:0] o_out_d_en
);

   if (NUM_CH != 7) begin : g_bad_count
      $error("channel count must be 7");
   end
   if (DEAD_CYCLES < 1 || DEAD_CYCLES > 255) begin : g_bad_dead
      $error("dead band must be 1 to 255 cycles");
   end

   localparam logic [7:0] DEAD_LOAD = 8'(DEAD_CYCLES);
   localparam logic [7:0] TSEL_TWO_MASK =
      SMALL_MEMORY ? `TSEL_TWO_SMALL_MASK : `TSEL_TWO_MASK;

   // Timer pair of a channel: {pwm timer, compare timer}, timer_1 = 0
   function automatic logic [5:0] timer_pair(input int ch,
         input logic [7:0] s1, input logic [7:0] s2);
      timer_idx_t c;
      timer_idx_t p;
      c = 3'd0;
      p = 3'd1;
      case (ch)
         0: begin
            c = (s1[1:0] == 2'b00) ? 3'd0 : 3'd2;
            p = (s1[1:0] == 2'b01) ? 3'd3 :
               (s1[1:0] == 2'b10) ? 3'd5 : 3'd1;
         end
         1: begin
            c = s1[2] ? 3'd4 : 3'd0;
            p = s1[2] ? 3'd3 : 3'd1;
         end
         2: begin
            c = s1[4] ? 3'd4 : 3'd0;
            p = 3'd1;
         end
         3: begin
            c = (s1[7:6] == 2'b00) ? 3'd0 : 3'd4;
            p = {s1[7:6], 1'b1};
         end
         4: begin
            c = (s2[1:0] == 2'b00 || SMALL_MEMORY) ? 3'd0 : 3'd6;
            p = (s2[1:0] == 2'b01) ? 3'd3 :
               (s2[1:0] == 2'b10) ? 3'd5 : 3'd1;
         end
         5: begin
            c = s2[2] ? 3'd6 : 3'd0;
            p = s2[2] ? 3'd3 : 3'd1;
         end
         default: begin
            c = s2[4] ? 3'd6 : 3'd0;
            p = 3'd1;
         end
      endcase
      return {p, c};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register file

   logic [7:0] ctrl_reg [NUM_CH];
   logic [7:0] ctrl_next [NUM_CH];
   logic [3:0] steer_reg [NUM_CH];
   logic [3:0] steer_next [NUM_CH];
   logic [7:0] tsel1_reg;
   logic [7:0] tsel1_next;
   logic [7:0] tsel2_reg;
   logic [7:0] tsel2_next;
   logic [6:0] irq_reg;
   logic [6:0] irq_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] trst_reg;
   logic [7:0] trst_next;
   logic [6:0] event_w;
   logic [6:0] trig_w;
   logic [2:0] cmp_idx_w [NUM_CH];
   logic [15:0] data_w [NUM_CH];
   logic [3:0] out_w [NUM_CH];
   logic [3:0] en_w [NUM_CH];

   always_comb begin
      tsel1_next = tsel1_reg;
      tsel2_next = tsel2_reg;
      rdata_next = 8'h00;
      trst_next = 8'h00;
      // An event in the clearing cycle survives the clear
      irq_next = irq_reg;
      for (int k = 0; k < NUM_CH; k++) begin
         ctrl_next[k] = ctrl_reg[k];
         steer_next[k] = steer_reg[k];
         if (i_wr && i_addr == 8'(`CH_CTRL_BASE + k)) begin
            ctrl_next[k] = (SMALL_MEMORY && k >= 5) ? `CTRL_RESET
                                                    : i_wdata;
         end
         if (i_wr && i_addr == 8'(`CH_STEER_BASE + k)) begin
            steer_next[k] = i_wdata[3:0];
         end
         if (i_rd && i_addr == 8'(`CH_CTRL_BASE + k)) begin
            rdata_next = ctrl_reg[k];
         end
         if (i_rd && i_addr == 8'(`CH_DATA_LO_BASE + k)) begin
            rdata_next = data_w[k][7:0];
         end
         if (i_rd && i_addr == 8'(`CH_DATA_HI_BASE + k)) begin
            rdata_next = data_w[k][15:8];
         end
         if (i_rd && i_addr == 8'(`CH_STEER_BASE + k)) begin
            rdata_next = {4'h0, steer_reg[k]};
         end
         if (trig_w[k]) begin
            trst_next[cmp_idx_w[k]] = 1'b1;
         end
      end
      if (i_wr && i_addr == `TSEL_ONE_ADDR) begin
         tsel1_next = i_wdata & `TSEL_ONE_MASK;
      end
      if (i_wr && i_addr == `TSEL_TWO_ADDR) begin
         tsel2_next = i_wdata & TSEL_TWO_MASK;
      end
      if (i_wr && i_addr == `IRQ_FLAG_ADDR) begin
         irq_next = irq_reg & ~i_wdata[6:0];
      end
      irq_next = irq_next | event_w;
      if (i_rd) begin
         case (i_addr)
            `TSEL_ONE_ADDR: rdata_next = tsel1_reg;
            `TSEL_TWO_ADDR: rdata_next = tsel2_reg;
            `IRQ_FLAG_ADDR: rdata_next = {1'b0, irq_reg};
            `PIN_STATE_ADDR: rdata_next = {1'b0, o_out_a};
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         for (int k = 0; k < NUM_CH; k++) begin
            ctrl_reg[k] <= `CTRL_RESET;
            steer_reg[k] <= `STEER_RESET;
         end
         tsel1_reg <= `TSEL_RESET;
         tsel2_reg <= `TSEL_RESET;
         irq_reg <= 7'h00;
         rdata_reg <= 8'h00;
         trst_reg <= 8'h00;
      end else begin
         for (int k = 0; k < NUM_CH; k++) begin
            ctrl_reg[k] <= ctrl_next[k];
            steer_reg[k] <= steer_next[k];
         end
         tsel1_reg <= tsel1_next;
         tsel2_reg <= tsel2_next;
         irq_reg <= irq_next;
         rdata_reg <= rdata_next;
         trst_reg <= trst_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_timer_reset = trst_reg;
   assign o_channel_irq_flag = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Channels

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      channel_mode_t mode;
      output_config_t ocfg;
      timer_idx_t cmp_idx;
      timer_idx_t pwm_idx;
      logic [15:0] cmp_cnt;
      logic [9:0] pwm_cnt;
      logic is_pwm;
      logic is_cmp;
      logic match_now;
      logic match_edge;
      logic [15:0] data_reg;
      logic [15:0] data_next;
      logic pin_reg;
      logic pin_next;
      logic match_prev_reg;
      logic match_prev_next;
      channel_mode_t mode_prev_reg;
      channel_mode_t mode_prev_next;
      logic [9:0] duty_reg;
      logic [9:0] duty_next;
      logic raw_reg;
      logic raw_next;
      logic [7:0] dead_reg;
      logic [7:0] dead_next;
      logic [3:0] out_reg;
      logic [3:0] out_next;
      logic [3:0] en_reg;
      logic [3:0] en_next;
      capture_if cif ();

      assign mode = channel_mode_t'(ctrl_reg[g][`CTRL_MODE_LSB +: 4]);
      assign ocfg = output_config_t'(ctrl_reg[g][`CTRL_OCFG_LSB +: 2]);
      assign {pwm_idx, cmp_idx} = timer_pair(g, tsel1_reg, tsel2_reg);
      // Sharing a timer needs no arbitration: channels read its count and OR their MODE_CMP_TRIG resets
      assign cmp_cnt = i_timer_count[cmp_idx];
      assign pwm_cnt = i_timer_count[pwm_idx][9:0];
      assign is_pwm = (mode[3:2] == 2'b11);
      assign is_cmp = (mode == MODE_CMP_TOGGLE) || (mode == MODE_CMP_SET)
         || (mode == MODE_CMP_CLEAR) || (mode == MODE_CMP_SOFT)
         || (mode == MODE_CMP_TRIG);
      assign match_now = is_cmp && (cmp_cnt == data_reg);
      // A timer that dwells on one value matches only once
      assign match_edge = match_now && !match_prev_reg;
      assign cif.pin = i_cap_pin[g];
      assign cif.mode = mode;
      assign event_w[g] = match_edge || cif.capture;
      assign trig_w[g] = match_edge && (mode == MODE_CMP_TRIG);
      assign cmp_idx_w[g] = cmp_idx;
      assign data_w[g] = data_reg;
      assign out_w[g] = out_reg;
      assign en_w[g] = en_reg;

      capture_edge_unit u_edge (
         .i_clk(i_clk),
         .i_rst_n(i_rst_n),
         .cap(cif.edge_side)
      );

      always_comb begin
         data_next = data_reg;
         pin_next = pin_reg;
         match_prev_next = match_now;
         mode_prev_next = mode;
         duty_next = duty_reg;
         raw_next = 1'b0;
         dead_next = dead_reg;
         out_next = 4'h0;
         en_next = 4'h0;
         if (i_wr && i_addr == 8'(`CH_DATA_LO_BASE + g)) begin
            data_next[7:0] = i_wdata;
         end
         if (i_wr && i_addr == 8'(`CH_DATA_HI_BASE + g)) begin
            data_next[15:8] = i_wdata;
         end
         if (cif.capture) begin
            data_next = cmp_cnt;
         end
         if (mode != mode_prev_reg) begin
            pin_next = (mode == MODE_CMP_CLEAR);
         end else if (match_edge) begin
            case (mode)
               MODE_CMP_TOGGLE: pin_next = ~pin_reg;
               MODE_CMP_SET: pin_next = 1'b1;
               MODE_CMP_CLEAR: pin_next = 1'b0;
               default: ;
            endcase
         end
         if (is_pwm) begin
            // The duty value takes effect at a period start or on entering a PWM mode
            if (pwm_cnt == 10'h000 || !mode_prev_reg[3] ||
                  !mode_prev_reg[2]) begin
               duty_next = {data_reg[7:0],
                  ctrl_reg[g][`CTRL_DUTY_LSB +: 2]};
               data_next[15:8] = data_reg[7:0];
            end
            raw_next = (pwm_cnt < duty_reg);
            if (raw_next != raw_reg) begin
               dead_next = DEAD_LOAD;
            end else if (dead_reg != 8'h00) begin
               dead_next = dead_reg - 8'h01;
            end
            case (ocfg)
               OCFG_SINGLE: begin
                  out_next = {4{raw_reg}};
                  en_next = steer_reg[g];
               end
               OCFG_FWD: begin
                  out_next = {raw_reg, 2'b00, 1'b1};
                  en_next = 4'hF;
               end
               OCFG_HALF: begin
                  out_next[0] = raw_reg && dead_reg == 8'h00;
                  out_next[1] = !raw_reg && dead_reg == 8'h00;
                  en_next = 4'h3;
               end
               OCFG_REV: begin
                  out_next = {2'b01, raw_reg, 1'b0};
                  en_next = 4'hF;
               end
            endcase
         end else begin
            dead_next = 8'h00;
            duty_next = 10'h000;
            out_next = {3'b000, pin_next};
            en_next[0] = (mode == MODE_CMP_TOGGLE) ||
               (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLEAR);
         end
         if (mode == MODE_OFF) begin
            pin_next = 1'b0;
            match_prev_next = 1'b0;
         end
      end

      always_ff @(posedge i_clk) begin
         if (!i_rst_n) begin
            data_reg <= 16'h0000;
            pin_reg <= 1'b0;
            match_prev_reg <= 1'b0;
            mode_prev_reg <= MODE_OFF;
            duty_reg <= 10'h000;
            raw_reg <= 1'b0;
            dead_reg <= 8'h00;
            out_reg <= 4'h0;
            en_reg <= 4'h0;
         end else begin
            data_reg <= data_next;
            pin_reg <= pin_next;
            match_prev_reg <= match_prev_next;
            mode_prev_reg <= mode_prev_next;
            duty_reg <= duty_next;
            raw_reg <= raw_next;
            dead_reg <= dead_next;
            out_reg <= out_next;
            en_reg <= en_next;
         end
      end

      assign o_out_a[g] = out_reg[0];
      assign o_out_b[g] = out_reg[1];
      assign o_out_c[g] = out_reg[2];
      assign o_out_d[g] = out_reg[3];
      assign o_out_a_en[g] = en_reg[0];
      assign o_out_b_en[g] = en_reg[1];
      assign o_out_c_en[g] = en_reg[2];
      assign o_out_d_en[g] = en_reg[3];
   end

endmodule

// *** tb/timer_bank_model.sv ***
// Stand-in for the eight external timers feeding the unit
`timescale 1ns/1ps
module timer_bank_model (
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic i_load,
   input wire logic [7:0][15:0] i_load_val,
   input wire logic [7:0] i_timer_reset,
   output logic [7:0][15:0] o_count
);
   // Load wins so the bench can freeze a known count at any time
   always_ff @(posedge i_clk) begin
      for (int k = 0; k < 8; k++) begin
         if (i_load)
            o_count[k] <= i_load_val[k];
         else if (i_timer_reset[k])
            o_count[k] <= 16'h0000;
         else if (i_run)
            o_count[k] <= o_count[k] + 16'h0001;
      end
   end
endmodule

// *** tb/capture_compare_pwm_unit_assertions.sv ***
// Port-level checker for the capture/compare/PWM unit
`timescale 1ns/1ps
module capture_compare_pwm_unit_assertions (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_timer_reset,
   input wire logic [6:0] o_channel_irq_flag,
   input wire logic [6:0] o_out_a,
   input wire logic [6:0] o_out_a_en,
   input wire logic [6:0] o_out_b,
   input wire logic [6:0] o_out_b_en,
   input wire logic [6:0] o_out_c,
   input wire logic [6:0] o_out_c_en,
   input wire logic [6:0] o_out_d,
   input wire logic [6:0] o_out_d_en
);
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [3:0] settle_reg;
   logic [3:0] settle_next;
   logic pwm;
   logic steady;

   // Shadow of channel four control; outputs judged once it has settled
   always_comb begin
      ctrl_next = ctrl_reg;
      settle_next = settle_reg;
      if (i_wr && i_addr == 8'h00) begin
         ctrl_next = i_wdata;
         settle_next = 4'h0;
      end else if (settle_reg != 4'hF) begin
         settle_next = settle_reg + 4'h1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_reg <= 8'h00;
         settle_reg <= 4'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         settle_reg <= settle_next;
      end
   end
   assign pwm = ctrl_reg[3:2] == 2'b11;
   assign steady = settle_reg > 4'h3;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   //////////////////////////////////////////////////////////////////////////
   a_tsel_unimpl: assert property (
      $past(i_rd) && $past(i_addr) == 8'h20
      |-> o_rdata[5] == 1'b0 && o_rdata[3] == 1'b0)
      else $error("timer select unimplemented bit reads one");
   a_flag_readback: assert property (
      $past(i_rd) && $past(i_addr) == 8'h22
      |-> o_rdata == {1'b0, $past(o_channel_irq_flag)})
      else $error("flag register read differs from flag outputs");
   a_timer_rst_pulse: assert property (o_timer_reset != 8'h00
      |=> o_timer_reset == 8'h00)
      else $error("timer reset longer than one cycle");
   a_reset_clears: assert property ($rose(i_rst_n)
      |-> o_channel_irq_flag == 7'h00 && o_out_a_en == 7'h00)
      else $error("flags or drive not cleared by reset");
   a_nonpwm_single: assert property (steady && !pwm
      |-> !o_out_b_en[0] && !o_out_c_en[0] && !o_out_d_en[0])
      else $error("extra output driven outside pwm");
   a_half_cd_free: assert property (
      steady && pwm && ctrl_reg[7:6] == 2'b10
      |-> !o_out_c_en[0] && !o_out_d_en[0])
      else $error("half bridge drives c or d");
   a_half_split: assert property (
      steady && pwm && ctrl_reg[7:6] == 2'b10
      && o_out_a_en[0] && o_out_b_en[0] |-> !(o_out_a[0] && o_out_b[0]))
      else $error("half bridge outputs overlap");
   a_fwd_drive: assert property (
      steady && pwm && ctrl_reg[7:6] == 2'b01
      |-> o_out_a[0] && !o_out_b[0] && !o_out_c[0])
      else $error("forward bridge levels wrong");
   a_rev_drive: assert property (
      steady && pwm && ctrl_reg[7:6] == 2'b11
      |-> o_out_c[0] && !o_out_a[0] && !o_out_d[0])
      else $error("reverse bridge levels wrong");
   a_init_low: assert property (i_wr && i_addr == 8'h00
      && i_wdata[3:0] == 4'h8 && ctrl_reg[3:0] != 4'h8
      |-> ##3 !o_out_a[0] && o_out_a_en[0])
      else $error("set mode does not start pin low");
   a_init_high: assert property (i_wr && i_addr == 8'h00
      && i_wdata[3:0] == 4'h9 && ctrl_reg[3:0] != 4'h9
      |-> ##3 o_out_a[0] && o_out_a_en[0])
      else $error("clear mode does not start pin high");
   a_soft_no_drive: assert property (steady && ctrl_reg[3:0] == 4'hA
      |-> !o_out_a_en[0])
      else $error("software compare drives the pin");
endmodule

bind capture_compare_pwm_unit capture_compare_pwm_unit_assertions
   u_capture_compare_pwm_unit_assertions (.i_clk, .i_rst_n, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .o_timer_reset, .o_channel_irq_flag,
   .o_out_a, .o_out_a_en, .o_out_b, .o_out_b_en, .o_out_c, .o_out_c_en,
   .o_out_d, .o_out_d_en);

// *** tb/capture_compare_pwm_unit_bench.sv ***
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/1ps
module capture_compare_pwm_unit_bench
   import ccpu_pkg::*;
;
   logic i_clk, i_rst_n, i_wr, i_rd, run, load, a0;
   logic [7:0] i_addr, i_wdata, o_rdata, o_timer_reset;
   logic [7:0][15:0] tcount, tval;
   logic [6:0] i_cap_pin, o_channel_irq_flag, o_out_a, o_out_a_en;
   logic [6:0] o_out_b, o_out_b_en, o_out_c, o_out_c_en, o_out_d, o_out_d_en;
   logic [3:0] got, msk;
   logic [7:0] small_rdata;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   int n;
   channel_mode_t cm_mode [5] = '{MODE_CMP_SET, MODE_CMP_CLEAR,
      MODE_CMP_TOGGLE, MODE_CMP_SOFT, MODE_CMP_TRIG};
   logic [1:0] pw_cfg [5] = '{2'b01, 2'b01, 2'b11, 2'b00, 2'b10};
   logic [15:0] pw_cnt [5] = '{16'h0200, 16'h0201, 16'h0200, 16'h0200,
      16'h0200};
   logic [3:0] pw_out [5] = '{4'h9, 4'h8, 4'h6, 4'hF, 4'h8};

   // Dead band shortened so half-bridge outputs come up quickly
   capture_compare_pwm_unit #(.DEAD_CYCLES(2)) u_capture_compare_pwm_unit (
      .i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_timer_count(tcount), .o_timer_reset, .i_cap_pin,
      .o_channel_irq_flag, .o_out_a, .o_out_a_en, .o_out_b, .o_out_b_en,
      .o_out_c, .o_out_c_en, .o_out_d, .o_out_d_en);
   // Small variant on the same bus; only its read data is compared
   capture_compare_pwm_unit #(.DEAD_CYCLES(2), .SMALL_MEMORY(1'b1))
      u_capture_compare_pwm_unit_small (
      .i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata(small_rdata), .i_timer_count(tcount), .o_timer_reset(),
      .i_cap_pin, .o_channel_irq_flag(), .o_out_a(), .o_out_a_en(),
      .o_out_b(), .o_out_b_en(), .o_out_c(), .o_out_c_en(), .o_out_d(),
      .o_out_d_en());
   timer_bank_model u_timer_bank_model (.i_clk, .i_run(run), .i_load(load),
      .i_load_val(tval), .i_timer_reset(o_timer_reset), .o_count(tcount));

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   //////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string w, input logic [15:0] s,
         input logic [15:0] e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic chkb(input string w, input logic s, input logic e);
      chk(w, {15'h0000, s}, {15'h0000, e});
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rdc(input string w, input logic [7:0] a,
         input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(w, {8'h00, o_rdata}, {8'h00, e});
   endtask
   task automatic load_timers;
      @(posedge i_clk);
      load <= 1'b1;
      @(posedge i_clk);
      load <= 1'b0;
   endtask
   task automatic pulse(input int c);
      i_cap_pin[c] <= ~i_cap_pin[c];
      tick(4);
      i_cap_pin[c] <= ~i_cap_pin[c];
      tick(4);
   endtask

   // A hang counts as a failure
   always @(posedge i_clk) begin
      cycles++;
      if (cycles > 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   initial begin
      i_rst_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_cap_pin = 7'h00;
      run = 1'b0;
      load = 1'b1;
      for (int k = 0; k < 8; k++)
         tval[k] = {k[3:0], 12'h123};
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      load <= 1'b0;
      rdc("ctrl reset", 8'h00, 8'h00);
      rdc("tsel reset", 8'h20, 8'h00);
      wr(8'h20, 8'hFC); // Selector four kept off its reserved code
      rdc("tsel mask", 8'h20, 8'hD4);
      wr(8'h21, 8'hFE);
      rdc("tsel two", 8'h21, 8'h16);
      chk("small tsel", {8'h00, small_rdata}, 16'h0002);
      wr(8'h05, 8'h30);
      rdc("ch9 ctrl", 8'h05, 8'h30);
      chk("small ch9", {8'h00, small_rdata}, 16'h0000);
      rdc("unmapped", 8'h40, 8'h00);
      // Capture: frozen timers, so the copied count is known
      wr(8'h20, 8'h01);
      for (int m = 0; m < 4; m++) begin
         n = (m < 2) ? 1 : (m == 2) ? 4 : 16;
         wr(8'h00, 8'h00);
         wr(8'h22, 8'h7F);
         i_cap_pin[0] <= (m == 0);
         wr(8'h00, 8'h04 + m[7:0]);
         for (int e = 1; e <= n; e++) begin
            if (e == n)
               chkb("cap early", o_channel_irq_flag[0], 1'b0);
            pulse(0);
         end
         tick(6);
         chkb("cap flag", o_channel_irq_flag[0], 1'b1);
         rdc("cap lo", 8'h08, tval[2][7:0]);
         rdc("cap hi", 8'h10, tval[2][15:8]);
      end
      wr(8'h20, 8'h40);
      wr(8'h03, 8'h05);
      pulse(3);
      tick(6);
      rdc("ch7 cap", 8'h13, tval[4][15:8]);
      // Compare: timer one runs up through the value 0x0040
      wr(8'h03, 8'h00);
      wr(8'h20, 8'h00);
      wr(8'h08, 8'h40);
      wr(8'h10, 8'h00);
      run <= 1'b1;
      for (int m = 0; m < 5; m++) begin
         wr(8'h00, 8'h00);
         wr(8'h22, 8'h7F);
         tval[0] = 16'h0000;
         load_timers();
         wr(8'h00, {4'h0, cm_mode[m]});
         tick(4);
         a0 = o_out_a[0];
         chkb("cmp early", o_channel_irq_flag[0], 1'b0);
         if (m < 2)
            chkb("cmp init", a0, m == 1);
         tick(80);
         chkb("cmp flag", o_channel_irq_flag[0], 1'b1);
         chkb("cmp drive", o_out_a_en[0], m < 3);
         if (m < 3)
            chkb("cmp pin", o_out_a[0], (m == 2) ? ~a0 : m == 0);
         if (m == 0)
            rdc("pin state", 8'h23, 8'h01);
         chkb("tmr clr", tcount[0] < 16'h0043, m == 4);
      end
      wr(8'h00, 8'h00);
      tick(3);
      chkb("off drive", o_out_a_en[0], 1'b0);
      rdc("flag reg", 8'h22, 8'h01);
      wr(8'h22, 8'h01);
      rdc("flag clr", 8'h22, 8'h00);
      // PWM: duty 0x201 from low byte and bits 5:4, timer two frozen
      run <= 1'b0;
      wr(8'h18, 8'h0F);
      wr(8'h08, 8'h80);
      for (int p = 0; p < 5; p++) begin
         wr(8'h00, 8'h00);
         tval[1] = pw_cnt[p];
         load_timers();
         wr(8'h00, {pw_cfg[p], 6'h1C});
         tick(20);
         got = {o_out_a[0], o_out_b[0], o_out_c[0], o_out_d[0]};
         msk = (p == 4) ? 4'hC : 4'hF;
         got = got & msk;
         chk("pwm out", {12'h000, got}, {12'h000, pw_out[p] & msk});
         if (p == 3)
            chk("steer", {12'h000, o_out_a_en[0], o_out_b_en[0],
               o_out_c_en[0], o_out_d_en[0]}, 16'h000F);
      end
      end_of_test();
   end
endmodule
